// >>> rtl/cms_slot_ctrl.sv
// message slot control: send selection, abort, receive filtering, register file
// Operation
// RQ1: chosen send slot set active; send starts
// RQ2: send failure clears active, takes abort
// RQ3: data send done sets done, status, stamp
// RQ4: send done interrupts only if slot enabled
// RQ5: sent data slot idles until reprogrammed
// RQ6: abort code cancels send, clears active
// RQ7: abort only while waiting, after failure
// RQ8: software zeroes slot control first
// RQ9: software waits for active low before loading
// RQ10: extended bit selects frame format
// RQ11: receive code sets accept request
// RQ12: receive search lowest slot first
// RQ13: match: data frame, masked id, same format
// RQ14: basic mode top two slots take remote frames
// RQ15: match sets active and done while storing
// RQ16: store on set done sets overwrite; here only in slots armed with code 4e
// RQ17: store overwrites id and length code
// RQ18: stamp stored; then status set, interrupt raised
// RQ19: unmatched frame dropped unwritten
// RQ20: codes 4e, 40, 00 clear done
// RQ21: software clears done, reads, rereads done
// RQ22: remote send code sets send request, remote frame
// RQ23: pending sends taken lowest slot first
// RQ24: data send uses the data send code
// RQ25: remote send code sets remote pending
// RQ26: hardware flag set beats software write
`include "cms_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module cms_slot_ctrl (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // protocol engine side
    input wire logic intermission,
    output logic tx_start,
    output cms_pkg::cms_tx_t tx_info,
    input wire logic tx_done,
    input wire logic tx_fail,
    input wire logic rx_valid,
    input wire cms_pkg::cms_frame_t rx_frame,
    input wire logic [15:0] stamp_count,
    // interrupt
    output logic irq
);
    import cms_pkg::*;

    localparam int NS = `CMS_SLOTS;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [NS-1:0] tr_r, tr_nxt, rr_r, rr_nxt, rm_r, rm_nxt, rl_r, rl_nxt;
    logic [NS-1:0] ra_r, ra_nxt, ovr_r, ovr_nxt, done_r, done_nxt;
    logic [NS-1:0] act_r, act_nxt, abt_r, abt_nxt, oven_r, oven_nxt;
    logic [28:0] id_r [NS], id_nxt [NS];
    logic [15:0] ts_r [NS], ts_nxt [NS];
    logic [3:0] dlc_r [NS], dlc_nxt [NS];
    logic [NS-1:0] ext_r, ext_nxt, istat_r, istat_nxt, imask_r, imask_nxt;
    logic [28:0] mask_r, mask_nxt;
    logic basic_r, basic_nxt;
    logic txb_r, txb_nxt, rxb_r, rxb_nxt;
    logic [3:0] txs_r, txs_nxt, rxs_r, rxs_nxt;
    logic tx_start_r, tx_start_nxt, irq_r, irq_nxt;
    cms_tx_t tx_info_r, tx_info_nxt;
    // bus slave state
    cms_wr_t wst_r, wst_nxt;
    logic awf_r, awf_nxt, wf_r, wf_nxt, rv_r, rv_nxt;
    logic [7:0] awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic [3:0] ws_r, ws_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // address inside a bank of sixteen slot words
    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
        return (a >= base) && (a < base + 8'h40);
    endfunction

    // slot index within a bank
    function automatic logic [3:0] bank_idx(input logic [7:0] a);
        return a[5:2];
    endfunction

    // acceptance filter; standard ids use the upper 11 bits
    function automatic logic id_hit(input logic [28:0] a, input logic [28:0] b,
                                    input logic [28:0] m, input logic ext);
        logic [28:0] em;
        em = ext ? m : (m & {11'h7ff, 18'h00000});
        return ((a ^ b) & em) == 29'h00000000;
    endfunction

    // ****************************************************************
    // bus handshakes: address and data in either order
    // ****************************************************************
    assign s_axi_awready = !awf_r && (wst_r == CMS_WR_IDLE);
    assign s_axi_wready = !wf_r && (wst_r == CMS_WR_IDLE);
    assign s_axi_bvalid = (wst_r == CMS_WR_RESP);
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rv_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rdata = rd_r;
    assign s_axi_rresp = rresp_r;
    assign tx_start = tx_start_r;
    assign tx_info = tx_info_r;
    assign irq = irq_r;

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    // software first, so hardware sets win ties
    always_comb begin
        logic wr_go, found, hit, ok;
        logic [3:0] wi, ri, fi;
        logic [7:0] code;
        logic [31:0] w;
        wr_go = 1'b0;
        found = 1'b0;
        hit = 1'b0;
        ok = 1'b0;
        wi = 4'h0;
        ri = 4'h0;
        fi = 4'h0;
        code = 8'h00;
        w = 32'h00000000;
        tr_nxt = tr_r; rr_nxt = rr_r; rm_nxt = rm_r; rl_nxt = rl_r;
        ra_nxt = ra_r; ovr_nxt = ovr_r; done_nxt = done_r; act_nxt = act_r;
        abt_nxt = abt_r; oven_nxt = oven_r;
        id_nxt = id_r; ts_nxt = ts_r; dlc_nxt = dlc_r;
        ext_nxt = ext_r; istat_nxt = istat_r; imask_nxt = imask_r;
        mask_nxt = mask_r; basic_nxt = basic_r;
        txb_nxt = txb_r; txs_nxt = txs_r; rxb_nxt = rxb_r; rxs_nxt = rxs_r;
        tx_start_nxt = 1'b0; tx_info_nxt = tx_info_r;
        wst_nxt = wst_r; awf_nxt = awf_r; wf_nxt = wf_r; rv_nxt = rv_r;
        awa_nxt = awa_r; wd_nxt = wd_r; ws_nxt = ws_r;
        bresp_nxt = bresp_r; rd_nxt = rd_r; rresp_nxt = rresp_r;

        // write channel capture
        if (s_axi_awvalid && s_axi_awready) begin
            awf_nxt = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wf_nxt = 1'b1;
            wd_nxt = s_axi_wdata;
            ws_nxt = s_axi_wstrb;
        end
        if (awf_r && wf_r && wst_r == CMS_WR_IDLE) begin
            wr_go = 1'b1;
            awf_nxt = 1'b0;
            wf_nxt = 1'b0;
            wst_nxt = CMS_WR_RESP;
            bresp_nxt = `CMS_RESP_OKAY;
        end
        if (wst_r == CMS_WR_RESP && s_axi_bready) begin
            wst_nxt = CMS_WR_IDLE;
        end

        // register writes
        if (wr_go) begin
            wi = bank_idx(awa_r);
            code = wd_r[7:0];
            if (in_bank(awa_r, `CMS_OFF_CTL)) begin
                if (txb_r && txs_r == wi) begin
                    // a slot on the wire takes only an abort
                    if (ws_r[0] && code == `CMS_CODE_ABORT) begin
                        abt_nxt[wi] = 1'b1; // RQ7
                    end
                end else if (ws_r[0]) begin
                    done_nxt[wi] = 1'b0; // RQ20
                    case (code)
                        `CMS_CODE_ABORT: begin
                            if (tr_r[wi]) begin
                                tr_nxt[wi] = 1'b0; // RQ6 RQ7
                                act_nxt[wi] = 1'b0; // RQ6
                                done_nxt[wi] = done_r[wi];
                            end else begin
                                done_nxt[wi] = done_r[wi];
                            end
                        end
                        `CMS_CODE_RXOV: begin
                            {tr_nxt[wi], rr_nxt[wi], rm_nxt[wi], rl_nxt[wi]} = 4'h4;
                            ra_nxt[wi] = 1'b0;
                            oven_nxt[wi] = 1'b1; // RQ20
                        end
                        `CMS_CODE_RTX: begin
                            {tr_nxt[wi], rr_nxt[wi], rm_nxt[wi], rl_nxt[wi]} = 4'ha; // RQ22
                            ra_nxt[wi] = 1'b1; // RQ25
                            oven_nxt[wi] = 1'b0;
                            ovr_nxt[wi] = 1'b0;
                        end
                        default: begin
                            // 00 stops, 40 arms receive, 80 arms send
                            {tr_nxt[wi], rr_nxt[wi], rm_nxt[wi], rl_nxt[wi]} = code[7:4]; // RQ11
                            ra_nxt[wi] = 1'b0;
                            oven_nxt[wi] = 1'b0;
                            ovr_nxt[wi] = 1'b0;
                            abt_nxt[wi] = 1'b0;
                        end
                    endcase
                end
            end else if (in_bank(awa_r, `CMS_OFF_ID)) begin
                // identifier is locked while the engine owns the slot
                if (!act_r[wi]) begin
                    w = merge({3'h0, id_r[wi]}, wd_r, ws_r);
                    id_nxt[wi] = w[28:0];
                end
            end else if (awa_r == `CMS_OFF_EXT) begin
                w = merge({16'h0000, ext_r}, wd_r, ws_r);
                ext_nxt = w[15:0]; // RQ10
            end else if (awa_r == `CMS_OFF_MASK) begin
                w = merge({3'h0, mask_r}, wd_r, ws_r);
                mask_nxt = w[28:0];
            end else if (awa_r == `CMS_OFF_ISTAT) begin
                // write one to clear
                w = merge(32'h00000000, wd_r, ws_r);
                istat_nxt = istat_r & ~w[15:0];
            end else if (awa_r == `CMS_OFF_IMASK) begin
                w = merge({16'h0000, imask_r}, wd_r, ws_r);
                imask_nxt = w[15:0];
            end else if (awa_r == `CMS_OFF_MODE) begin
                if (ws_r[0]) begin
                    basic_nxt = wd_r[0];
                end
            end else if (!in_bank(awa_r, `CMS_OFF_STAMP)) begin
                bresp_nxt = `CMS_RESP_DECERR;
            end
        end

        // send outcome from the protocol engine
        if (txb_r && tx_fail) begin
            act_nxt[txs_r] = 1'b0; // RQ2
            txb_nxt = 1'b0;
            if (abt_r[txs_r]) begin
                tr_nxt[txs_r] = 1'b0; // RQ2 RQ7
                ra_nxt[txs_r] = 1'b0;
                abt_nxt[txs_r] = 1'b0;
            end
        end else if (txb_r && tx_done) begin
            txb_nxt = 1'b0;
            act_nxt[txs_r] = 1'b0;
            tr_nxt[txs_r] = 1'b0;
            abt_nxt[txs_r] = 1'b0;
            ts_nxt[txs_r] = stamp_count; // RQ3
            istat_nxt[txs_r] = 1'b1; // RQ3 RQ26
            if (ra_r[txs_r]) begin
                // remote sent: rr set but rm left set, so no frame matches the slot
                ra_nxt[txs_r] = 1'b0;
                rr_nxt[txs_r] = 1'b1;
            end else begin
                done_nxt[txs_r] = 1'b1; // RQ3 RQ26
                rr_nxt[txs_r] = 1'b0; // RQ5
            end
        end

        // second store cycle: release slot and flag it
        if (rxb_r) begin
            rxb_nxt = 1'b0;
            act_nxt[rxs_r] = 1'b0;
            istat_nxt[rxs_r] = 1'b1; // RQ18 RQ26
        end

        // acceptance search, lowest slot first
        if (rx_valid) begin
            for (int n = NS - 1; n >= 0; n--) begin // RQ12
                ok = !rx_frame.remote || (basic_r && 4'(n) >= `CMS_BASIC_LO); // RQ13 RQ14
                hit = (rr_r[n] || ra_r[n]) && !rm_r[n] == !ra_r[n] && ok &&
                      !(txb_r && txs_r == 4'(n)) && (ext_r[n] == rx_frame.ext) &&
                      id_hit(rx_frame.id, id_r[n], mask_r, rx_frame.ext); // RQ13
                if (hit) begin
                    found = 1'b1;
                    fi = 4'(n);
                end
            end
            // no match: nothing is written and the frame is gone
            if (found) begin // RQ19
                act_nxt[fi] = 1'b1; // RQ15
                done_nxt[fi] = 1'b1; // RQ15 RQ26
                if (done_r[fi] && oven_r[fi]) begin
                    ovr_nxt[fi] = 1'b1; // RQ16
                end
                id_nxt[fi] = rx_frame.id; // RQ17
                dlc_nxt[fi] = rx_frame.dlc; // RQ17
                ts_nxt[fi] = stamp_count; // RQ18
                if (ra_r[fi]) begin
                    // data came before the remote: cancel it
                    tr_nxt[fi] = 1'b0;
                    ra_nxt[fi] = 1'b0;
                    rm_nxt[fi] = 1'b0;
                    rr_nxt[fi] = 1'b1;
                end
                rxb_nxt = 1'b1;
                rxs_nxt = fi;
            end
        end

        // send selection at intermission, lowest slot first
        found = 1'b0;
        if (intermission && !txb_nxt) begin
            for (int n = NS - 1; n >= 0; n--) begin // RQ23
                if (tr_nxt[n] && !act_nxt[n] && !(basic_r && 4'(n) >= `CMS_BASIC_LO)) begin
                    found = 1'b1;
                    ri = 4'(n);
                end
            end
            if (found) begin
                act_nxt[ri] = 1'b1; // RQ1
                txb_nxt = 1'b1;
                txs_nxt = ri;
                tx_start_nxt = 1'b1; // RQ1
                tx_info_nxt = '{slot: ri, id: id_nxt[ri], ext: ext_nxt[ri], remote: ra_nxt[ri]}; // RQ10
            end
        end

        // interrupt only for enabled slots
        irq_nxt = |(istat_nxt & imask_nxt); // RQ4 RQ18

        // read channel
        if (rv_r && s_axi_rready) begin
            rv_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rv_r) begin
            rv_nxt = 1'b1;
            rresp_nxt = `CMS_RESP_OKAY;
            ri = bank_idx(s_axi_araddr);
            rd_nxt = 32'h00000000;
            if (in_bank(s_axi_araddr, `CMS_OFF_CTL)) begin
                rd_nxt[`CMS_B_TR] = tr_r[ri];
                rd_nxt[`CMS_B_RR] = rr_r[ri];
                rd_nxt[`CMS_B_RM] = rm_r[ri];
                rd_nxt[`CMS_B_RL] = rl_r[ri];
                rd_nxt[`CMS_B_RA] = ra_r[ri];
                rd_nxt[`CMS_B_OVR] = ovr_r[ri];
                rd_nxt[`CMS_B_DONE] = done_r[ri];
                rd_nxt[`CMS_B_ACT] = act_r[ri];
                rd_nxt[`CMS_B_OVEN] = oven_r[ri];
            end else if (in_bank(s_axi_araddr, `CMS_OFF_ID)) begin
                rd_nxt = {3'h0, id_r[ri]};
            end else if (in_bank(s_axi_araddr, `CMS_OFF_STAMP)) begin
                rd_nxt = {12'h000, dlc_r[ri], ts_r[ri]};
            end else if (s_axi_araddr == `CMS_OFF_EXT) begin
                rd_nxt = {16'h0000, ext_r};
            end else if (s_axi_araddr == `CMS_OFF_MASK) begin
                rd_nxt = {3'h0, mask_r};
            end else if (s_axi_araddr == `CMS_OFF_ISTAT) begin
                rd_nxt = {16'h0000, istat_r};
            end else if (s_axi_araddr == `CMS_OFF_IMASK) begin
                rd_nxt = {16'h0000, imask_r};
            end else if (s_axi_araddr == `CMS_OFF_MODE) begin
                rd_nxt = {31'h00000000, basic_r};
            end else begin
                rresp_nxt = `CMS_RESP_DECERR;
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // everything freezes while ce is low, except that reset still clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tr_r <= 16'h0000; rr_r <= 16'h0000; rm_r <= 16'h0000; rl_r <= 16'h0000;
            ra_r <= 16'h0000; ovr_r <= 16'h0000; done_r <= 16'h0000;
            act_r <= 16'h0000; abt_r <= 16'h0000; oven_r <= 16'h0000;
            for (int n = 0; n < NS; n++) begin
                id_r[n] <= 29'h00000000;
                ts_r[n] <= 16'h0000;
                dlc_r[n] <= 4'h0;
            end
            ext_r <= 16'h0000; istat_r <= 16'h0000; imask_r <= 16'h0000;
            mask_r <= 29'h1fffffff;
            basic_r <= 1'b0;
            txb_r <= 1'b0; txs_r <= 4'h0; rxb_r <= 1'b0; rxs_r <= 4'h0;
            tx_start_r <= 1'b0; tx_info_r <= '0; irq_r <= 1'b0;
            wst_r <= CMS_WR_IDLE; awf_r <= 1'b0; wf_r <= 1'b0; rv_r <= 1'b0;
            awa_r <= 8'h00; wd_r <= 32'h00000000; ws_r <= 4'h0;
            bresp_r <= 2'h0; rd_r <= 32'h00000000; rresp_r <= 2'h0;
        end else if (ce) begin
            tr_r <= tr_nxt; rr_r <= rr_nxt; rm_r <= rm_nxt; rl_r <= rl_nxt;
            ra_r <= ra_nxt; ovr_r <= ovr_nxt; done_r <= done_nxt;
            act_r <= act_nxt; abt_r <= abt_nxt; oven_r <= oven_nxt;
            id_r <= id_nxt; ts_r <= ts_nxt; dlc_r <= dlc_nxt;
            ext_r <= ext_nxt; istat_r <= istat_nxt; imask_r <= imask_nxt;
            mask_r <= mask_nxt;
            basic_r <= basic_nxt;
            txb_r <= txb_nxt; txs_r <= txs_nxt; rxb_r <= rxb_nxt; rxs_r <= rxs_nxt;
            tx_start_r <= tx_start_nxt; tx_info_r <= tx_info_nxt; irq_r <= irq_nxt;
            wst_r <= wst_nxt; awf_r <= awf_nxt; wf_r <= wf_nxt; rv_r <= rv_nxt;
            awa_r <= awa_nxt; wd_r <= wd_nxt; ws_r <= ws_nxt;
            bresp_r <= bresp_nxt; rd_r <= rd_nxt; rresp_r <= rresp_nxt;
        end
    end

endmodule

`default_nettype wire

// >>> include/cms_cfg.svh
// constants for the message slot control block: offsets, codes, bit positions
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH

// ****************************************************************
// geometry
// ****************************************************************
`define CMS_SLOTS 16
`define CMS_BASIC_LO 4'he
`define CMS_ID_W 29
`define CMS_STD_SHIFT 18
`define CMS_TS_W 16

// ****************************************************************
// byte offsets of the register map
// ****************************************************************
`define CMS_OFF_CTL 8'h00
`define CMS_OFF_ID 8'h40
`define CMS_OFF_STAMP 8'h80
`define CMS_OFF_EXT 8'hc0
`define CMS_OFF_MASK 8'hc4
`define CMS_OFF_ISTAT 8'hc8
`define CMS_OFF_IMASK 8'hcc
`define CMS_OFF_MODE 8'hd0

// ****************************************************************
// slot control command codes
// ****************************************************************
`define CMS_CODE_INIT 8'h00
`define CMS_CODE_TX 8'h80
`define CMS_CODE_RX 8'h40
`define CMS_CODE_RXOV 8'h4e
`define CMS_CODE_RTX 8'ha0
`define CMS_CODE_ABORT 8'h0f

// ****************************************************************
// slot control read-back bit positions
// ****************************************************************
`define CMS_B_ACT 0
`define CMS_B_DONE 1
`define CMS_B_OVR 2
`define CMS_B_RA 3
`define CMS_B_RL 4
`define CMS_B_RM 5
`define CMS_B_RR 6
`define CMS_B_TR 7
`define CMS_B_OVEN 8
`define CMS_B_DLC 16

// ****************************************************************
// bus answers
// ****************************************************************
`define CMS_RESP_OKAY 2'h0
`define CMS_RESP_DECERR 2'h3

`endif

// >>> include/cms_pkg.sv
// types shared by the message slot control block
package cms_pkg;

    // ****************************************************************
    // carriers
    // ****************************************************************
    // frame handed over by the protocol engine after reception
    typedef struct packed {
        logic [28:0] id;
        logic ext;
        logic remote;
        logic [3:0] dlc;
    } cms_frame_t;

    // frame chosen for sending, handed to the protocol engine
    typedef struct packed {
        logic [3:0] slot;
        logic [28:0] id;
        logic ext;
        logic remote;
    } cms_tx_t;

    // write channel state of the bus slave
    typedef enum logic [0:0] {
        CMS_WR_IDLE = 1'b0,
        CMS_WR_RESP = 1'b1
    } cms_wr_t;

endpackage

// >>> tb/cms_slot_ctrl_checker.sv
// assertion checker for the message slot control block
`timescale 1ns/10ps
`default_nettype none
module cms_slot_ctrl_checker (
    // clock and reset
    input wire logic aclk, input wire logic aresetn, input wire logic ce,
    // bus handshakes
    input wire logic s_axi_awready, input wire logic s_axi_wready, input wire logic s_axi_bvalid,
    input wire logic s_axi_bready, input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid, input wire logic s_axi_arready, input wire logic s_axi_rvalid,
    input wire logic s_axi_rready, input wire logic [31:0] s_axi_rdata,
    // engine side
    input wire logic intermission, input wire logic tx_start,
    input wire logic tx_done, input wire logic tx_fail
);
    logic busy_r;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);
    // send on the wire
    always_ff @(posedge aclk) busy_r <= aresetn && (tx_start || (busy_r && !(tx_done || tx_fail)));
    sequence read_taken; s_axi_arvalid && s_axi_arready; endsequence
    tx_pulse_a: assert property (tx_start |=> !tx_start) else $error("start too long");
    start_cause_a: assert property (tx_start |-> $past(intermission)) else $error("no gap");
    busy_hold_a: assert property (busy_r |-> !tx_start) else $error("start while busy");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    read_answer_a: assert property (read_taken |=> s_axi_rvalid) else $error("read late");
    arready_gate_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
endmodule
bind cms_slot_ctrl cms_slot_ctrl_checker u_cms_slot_ctrl_checker (.*);
`default_nettype wire

// >>> tb/cms_engine_model.sv
// far-side engine model: gaps, send outcome, received frames
`timescale 1ns/10ps
`default_nettype none
module cms_engine_model (
    // clock, reset, launch
    input wire logic aclk, input wire logic aresetn,
    input wire logic tx_start, input wire logic fail_mode,
    // link events
    output logic intermission, output logic tx_done, output logic tx_fail,
    output logic rx_valid, output cms_pkg::cms_frame_t rx_frame, output logic [15:0] stamp_count
);
    import cms_pkg::*;
    initial {intermission, tx_done, tx_fail, rx_valid, rx_frame} = '0;
    // free-running stamp counter
    always_ff @(posedge aclk) stamp_count <= aresetn ? stamp_count + 16'h0001 : 16'h0000;
    // one answer per launch; failure comes later
    always @(posedge aclk) if (tx_start) begin
        repeat (fail_mode ? 9 : 5) @(posedge aclk);
        tx_done <= !fail_mode;
        tx_fail <= fail_mode;
        @(posedge aclk);
        {tx_done, tx_fail} <= 2'h0;
    end
    task automatic gap();
        @(posedge aclk);
        intermission <= 1'b1;
        @(posedge aclk);
        intermission <= 1'b0;
    endtask
    // frame shown one cycle, then scrambled
    task automatic deliver(input cms_frame_t f);
        @(posedge aclk);
        rx_valid <= 1'b1;
        rx_frame <= f;
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_frame <= ~f;
        @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// >>> tb/test_cms_slot_ctrl.sv
// self-checking bench for the message slot control block
`include "cms_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module test_cms_slot_ctrl;
    import cms_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic intermission, tx_start, tx_done, tx_fail, rx_valid, fail_mode;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] stamp_count, st;
    cms_tx_t tx_info;
    cms_frame_t rx_frame, f;
    int num_errors = 0, check_count = 0;
    cms_slot_ctrl u_cms_slot_ctrl (.ce(1'b1), .*);
    cms_engine_model u_cms_engine_model (.*);
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one bus cycle; each channel released at the edge that takes it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {w, w, w, a, d};
        {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {!w, !w, a};
        repeat (60) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            q = w ? {30'h0, s_axi_bresp} : s_axi_rdata;
            if (w ? s_axi_bvalid : s_axi_rvalid) begin
                {s_axi_bready, s_axi_rready} <= 2'h0;
                return;
            end
        end
        num_errors++;
        summarize();
    endtask
    task automatic await_done();
        int n;
        for (n = 0; n < 100 && tx_done !== 1'b1 && tx_fail !== 1'b1; n++) @(negedge aclk);
        st = stamp_count;
        if (n == 100) begin
            num_errors++;
            summarize();
        end
    endtask
    // send, fail, abort
    task automatic s_send();
        xfer(1, 8'h04, 32'h0, v); xfer(1, 8'h0c, 32'h0, v); xfer(1, 8'hcc, 32'h2, v);
        xfer(1, 8'h0c, `CMS_CODE_TX, v); xfer(1, 8'h04, `CMS_CODE_TX, v);
        u_cms_engine_model.gap();
        xfer(0, 8'h04, 32'h0, v); chk(v[0], 1'b1);
        chk(tx_info.slot, 4'h1);
        await_done();
        repeat (3) @(posedge aclk);
        xfer(0, 8'h04, 32'h0, v); chk(v[2:0], 3'h2);
        xfer(0, 8'h84, 32'h0, v); chk(v[15:0], st);
        xfer(0, 8'hc8, 32'h0, v); chk(v[1], 1'b1);
        chk(irq, 1'b1);
        fail_mode <= 1'b1;
        u_cms_engine_model.gap();
        @(negedge aclk); chk(tx_info.slot, 4'h3);
        await_done();
        repeat (3) @(posedge aclk);
        xfer(0, 8'h0c, 32'h0, v); chk({v[7], v[0]}, 2'h2);
        xfer(1, 8'h0c, `CMS_CODE_ABORT, v); xfer(0, 8'h0c, 32'h0, v); chk(v[7:0], 8'h0);
    endtask
    // receive paths
    task automatic s_recv();
        xfer(1, 8'h08, 32'h0, v); xfer(0, 8'h08, 32'h0, v); chk(v[0], 1'b0);
        xfer(1, 8'h48, 32'h0a5c0000, v); xfer(1, 8'h08, `CMS_CODE_RXOV, v);
        f = '{id: 29'h0a5c0000, ext: 1'b0, remote: 1'b0, dlc: 4'h5};
        u_cms_engine_model.deliver(f); u_cms_engine_model.deliver(f);
        xfer(0, 8'h08, 32'h0, v); chk(v[6:0], 7'h46);
        xfer(0, 8'h88, 32'h0, v); chk(v[19:16], 4'h5);
        xfer(0, 8'hc8, 32'h0, v); chk(v[2], 1'b1);
        xfer(1, 8'hc8, 32'h4, v); f.remote = 1'b1;
        u_cms_engine_model.deliver(f); f = '{id: 29'h0a600000, ext: 1'b0, remote: 1'b0, dlc: 4'h1};
        u_cms_engine_model.deliver(f);
        xfer(0, 8'hc8, 32'h0, v); chk(v[2], 1'b0);
        xfer(1, 8'h08, `CMS_CODE_RX, v); xfer(0, 8'h08, 32'h0, v); chk(v[1], 1'b0);
        xfer(1, 8'h18, `CMS_CODE_RTX, v); xfer(0, 8'h18, 32'h0, v); chk(v[7:0], 8'ha8);
        xfer(1, 8'hf0, 32'h0, v); chk(v, 32'h3);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fail_mode} = '0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        s_send();
        s_recv();
        summarize();
    end
endmodule
`default_nettype wire
